// *** dv/mdcr_bus_master.sv ***
// two-wire bus master model that drives the register bank
`timescale 1ns/1ps
module mdcr_bus_master (
  input wire logic core_clk,
  input wire logic sda_line,
  input wire logic slow,
  output logic scl,
  output logic sda_low,
  output logic res_valid,
  output logic [8:0] res
);
  logic [7:0] rx; // bits read back from the device
  logic ok; // every byte so far was acked
  // bus idle: clock high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    res_valid = 1'b0;
    res = 9'h000;
  end
  // one clock phase; the slow mode stretches it to test patience
  task automatic half();
    repeat (slow ? 7 : 3) @(posedge core_clk);
  endtask
  // one bit, sampled while the clock is high
  task automatic bit_x(input logic b, output logic s);
    sda_low <= ~b;
    half();
    scl <= 1'b1;
    half();
    s = sda_line;
    scl <= 1'b0;
    half();
  endtask
  // start or repeated start: data falls while clock high
  task automatic start_c();
    sda_low <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b1;
    half();
    scl <= 1'b0;
    half();
  endtask
  // byte msb first, then the acknowledge slot
  task automatic put(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    ok &= ~s;
  endtask
  // stop, then one pulse carrying {acked, data}
  task automatic report(input logic [7:0] d);
    sda_low <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
    res <= {ok, d};
    res_valid <= 1'b1;
    @(posedge core_clk);
    res_valid <= 1'b0;
  endtask
  // register write: address, offset, one data byte, stop
  task automatic wr(input logic [6:0] dev, input logic [7:0] a,
                    input logic [7:0] d);
    ok = 1'b1;
    start_c();
    put({dev, 1'b0});
    if (ok) put(a);
    if (ok) put(d);
    report(8'h00);
  endtask
  // register read: pointer, repeated start, one byte, nack, stop
  task automatic rd(input logic [6:0] dev, input logic [7:0] a);
    logic s;
    rx = 8'hFF;
    ok = 1'b1;
    start_c();
    put({dev, 1'b0});
    if (ok) put(a);
    if (ok) begin
      start_c();
      put({dev, 1'b1});
      for (int i = 7; i >= 0; i--) bit_x(1'b1, rx[i]);
      bit_x(1'b1, s); // nack closes the read
    end
    report(rx);
  endtask
endmodule

// *** dv/tb_motor_driver_i2c_config_regs.sv ***
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
module tb_motor_driver_i2c_config_regs;
  import mdcr_pkg::*;
  logic core_clk, resetn, scl, m_low, slow, rv, sda_oe_n, fpin_oe_n;
  logic ocr, olbo, hiz, olc; // olc: open-load check pulse
  logic [8:0] res; // bus result {acked, data}
  logic [3:0] pins, etc;
  mdcr_fault_evt_t evt;
  mdcr_bridge_cfg_t cfg;
  logic [31:0] r; // random state
  logic [8:0] exp_q[$]; // expected bus results, oldest first
  logic [7:0] v;
  logic [7:0] pv[6] = '{8'h00, 8'h40, 8'h02, 8'h09, 8'h14, 8'hFF};
  int error_cnt, checks, olc_n;
  wire sda_line = ~(m_low | ~sda_oe_n); // pulled-up open drain
  mdcr_config_regs #(.RETRY_CYCLES(8)) u_mdcr_config_regs (
    .core_clk(core_clk), .resetn(resetn), .scl_in(scl),
    .sda_in(sda_line), .sda_out(), .sda_oe_n(sda_oe_n),
    .error_pin_low_in(fpin_oe_n), .error_pin_low_out(),
    .error_pin_low_oe_n(fpin_oe_n), .bridge_pin_in(pins),
    .fault_evt(evt), .bridge_cfg(cfg), .overcurrent_response(ocr),
    .open_load_bridge_off(olbo), .open_load_check_start(olc),
    .bridge_hiz(hiz), .edge_time_cycles(etc));
  mdcr_bus_master u_mdcr_bus_master (.core_clk(core_clk),
    .sda_line(sda_line), .slow(slow), .scl(scl), .sda_low(m_low),
    .res_valid(rv), .res(res));
  // random source for data, pins and bus speed
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one comparison, counted
  task automatic check(input string n, input logic [8:0] seen, e);
    checks++;
    if (seen !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, seen);
    end
  endtask
  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // bus wrappers note the expected result first
  task automatic bus_wr(input logic [6:0] d, input logic [7:0] a, x);
    r = lfsr(r);
    slow <= r[3];
    exp_q.push_back(9'h100);
    u_mdcr_bus_master.wr(d, a, x);
  endtask
  task automatic bus_rd(input logic [6:0] d, input logic [7:0] a,
                        input logic [8:0] e);
    r = lfsr(r);
    slow <= r[3];
    exp_q.push_back(e);
    u_mdcr_bus_master.rd(d, a);
  endtask
  // watcher: each bus result takes the oldest note
  always @(posedge core_clk) begin
    if (rv === 1'b1) begin
      if (exp_q.size() == 0) check("bus_extra", res, 9'h000);
      else check("bus_result", res, exp_q.pop_front());
    end
  end
  // count open-load check pulses
  always @(posedge core_clk) begin
    if (olc === 1'b1) olc_n++;
  end
  // 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    end_of_test();
  end
  // main sequence
  initial begin
    resetn = 1'b0;
    pins = 4'h0;
    evt = '0;
    slow = 1'b0;
    r = 32'hdaf58f2c;
    error_cnt = 0;
    checks = 0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("cfg_reset", cfg, 9'h001);
    bus_rd(7'h60, 8'h00, 9'h160);
    bus_rd(7'h60, 8'h01, 9'h100);
    bus_rd(7'h60, 8'h02, 9'h100);
    bus_rd(7'h60, 8'h03, 9'h140);
    bus_rd(7'h60, 8'h04, 9'h100);
    // edge rate: slow then fast, read-only bits stay clear
    for (int i = 1; i >= 0; i--) begin
      v = {8{i[0]}};
      bus_wr(7'h60, 8'h03, v);
      bus_rd(7'h60, 8'h03, {2'b10, v[6], 6'h00});
      check("edge", {cfg[0], etc}, {v[6], v[6] ? 4'h8 : 4'h4});
    end
    // every mode, both bridge sources, random inputs
    for (int m = 0; m < 4; m++) begin
      r = lfsr(r);
      v = {r[7:3], m[0], m[1:0]};
      pins <= r[11:8];
      bus_wr(7'h60, 8'h01, v);
      bus_rd(7'h60, 8'h01, {1'b1, v});
      check("trq_mode", {cfg[8], cfg[3:2]}, {v[7], v[1:0]});
      check("bridge_in", cfg[7:4], v[2] ? v[6:3] : pins);
    end
    // overcurrent, thermal, undervoltage pulse, then clear
    evt <= 4'hB;
    @(posedge core_clk);
    evt <= 4'h0;
    repeat (3) @(posedge core_clk);
    check("fault_pin", fpin_oe_n, 9'h0);
    bus_rd(7'h60, 8'h03, 9'h11B);
    bus_wr(7'h60, 8'h02, 8'h80);
    bus_rd(7'h60, 8'h02, 9'h100);
    bus_rd(7'h60, 8'h03, 9'h100);
    // open load survives the clear
    evt <= 4'h4;
    @(posedge core_clk);
    evt <= 4'h0;
    bus_wr(7'h60, 8'h02, 8'h80);
    bus_rd(7'h60, 8'h03, 9'h114);
    // protection settings against their outputs
    foreach (pv[k]) begin
      v = pv[k];
      bus_wr(7'h60, 8'h02, v);
      bus_rd(7'h60, 8'h02, {1'b1, v & 8'h5F});
      check("ocp_resp", ocr, v[3]);
      check("old_off", {olbo, hiz}, {2{v[0]}});
      check("decay", cfg[1], v[4]);
      check("pin_out", fpin_oe_n, v[6] | v[1]);
      bus_rd(7'h60, 8'h03, {4'h8, ~(v[6] | v[1]), 4'h4});
    end
    check("olc_count", olc_n[8:0], 9'h002);
    // latch mode holds the bridge off past the retry wait, auto does not
    for (int l = 1; l >= 0; l--) begin
      bus_wr(7'h60, 8'h02, {4'h0, l[0], 3'h0});
      evt <= 4'h8;
      @(posedge core_clk);
      evt <= 4'h0;
      repeat (20) @(posedge core_clk);
      check("ocp_hiz", hiz, l[0]);
    end
    // new bus address from the next start only
    bus_wr(7'h60, 8'h00, 8'hA1);
    bus_rd(7'h21, 8'h00, 9'h121);
    bus_rd(7'h60, 8'h00, 9'h0FF);
    // a mid-run reset brings back the default bus address
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    bus_rd(7'h60, 8'h00, 9'h160);
    end_of_test();
  end
endmodule

// *** hw/mdcr_bus_edges.sv ***
// edge, start and stop detection on the two-wire bus pins
`timescale 1ns/1ps
module mdcr_bus_edges (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen
);
  import mdcr_pkg::*;

  logic scl_q; // previous clock level
  logic sda_q; // previous data level

  // pins are already synchronous, one stage of history is enough
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  // data moving while the clock stays high frames a transfer
  assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_seen = scl_in & scl_q & ~sda_q & sda_in;
endmodule

// *** hw/mdcr_config_regs.sv ***
// two-wire slave and configuration registers of the motor driver
//
// Contract
// - address register: 7-bit field, reset 1100000b
// - address at 0x00, answers 0x60 after reset
// - bridge_control at 0x01 resets to zero
// - bit 7 halves torque current limit
// - bits 6..3 are bridge inputs four..one
// - bit 2 picks pins or register inputs
// - mode field: four-pin, two-pin, parallel, half
// - protection_control at 0x02, bit 5 reserved
// - clear command clears faults except open load
// - clear bit returns to zero by itself
// - bit 6 disables the fault pin
// - bit 3 picks auto retry or latch
// - writing bit 2 starts open-load check
// - bit 1 hides open load from pin
// - bit 0 turns bridge off on open load
// - status at 0x03 resets to 0x40
// - edge rate bit: 150 ns or 300 ns
// - status mirrors fault pin and four flags
// - write: address, register, data, stop, acks
// - read: pointer, repeated start, byte, nack
`timescale 1ns/1ps
`include "mdcr_params.svh"
module mdcr_config_regs #(
  parameter int RETRY_CYCLES = `MDCR_RETRY_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic error_pin_low_in,
  output logic error_pin_low_out,
  output logic error_pin_low_oe_n,
  input wire logic [3:0] bridge_pin_in,
  input wire mdcr_pkg::mdcr_fault_evt_t fault_evt,
  output mdcr_pkg::mdcr_bridge_cfg_t bridge_cfg,
  output logic overcurrent_response,
  output logic open_load_bridge_off,
  output logic open_load_check_start,
  output logic bridge_hiz,
  output logic [3:0] edge_time_cycles
);
  import mdcr_pkg::*;

  localparam logic [3:0] EDGE_FAST = 4'(`MDCR_EDGE_FAST_CYC);
  localparam logic [3:0] EDGE_SLOW = 4'(`MDCR_EDGE_SLOW_CYC);

  // bus edge events
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  // serial slave state
  mdcr_state_t state; // transfer phase
  logic [7:0] shift_in; // received bits, msb first
  logic [7:0] shift_out; // byte being sent
  logic [3:0] bit_cnt; // clock rises seen in this byte
  logic [7:0] reg_ptr; // register pointer
  logic read_dir; // direction bit of the address byte
  logic [6:0] active_addr; // address in force for this transfer
  logic wr_strobe; // one-cycle register write
  logic [7:0] wr_data; // data with the strobe
  logic [7:0] rd_data; // selected read byte
  logic bus_release; // bus cut off by the fault pin pulled low by others while bit 6 disables it

  // registers
  logic [6:0] bus_address; // own bus address
  logic [7:0] bridge_control; // torque, inputs, source, mode
  logic [7:0] protection_control; // bits 6 and 4..0 stored, bit 5 held zero
  logic clear_faults_cmd; // self-clearing clear bit
  logic edge_rate_select; // slow edges when set
  logic [3:0] fault_flags; // ocp, open load, thermal, undervoltage

  mdcr_bus_edges u_edges (
    .core_clk(core_clk),
    .resetn(resetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );

  mdcr_fault_core #(
    .RETRY_CYCLES(RETRY_CYCLES)
  ) u_faults (
    .core_clk(core_clk),
    .resetn(resetn),
    .fault_evt(fault_evt),
    .clear_pulse(clear_faults_cmd),
    .old_suppress(protection_control[`MDCR_PROT_OLD_SUPP]),
    .pin_disable(protection_control[`MDCR_PROT_PIN_DIS]),
    .latch_mode(protection_control[`MDCR_PROT_OCP_RESP]),
    .old_bridge_off(protection_control[`MDCR_PROT_OLD_OFF]),
    .flags(fault_flags),
    .pin_oe_n(error_pin_low_oe_n),
    .bridge_hiz(bridge_hiz)
  );

  // open-drain lines only ever pull low
  assign sda_out = 1'h0;
  assign error_pin_low_out = 1'h0;

  // a disabled fault pin held low by others detaches this slave
  assign bus_release = protection_control[`MDCR_PROT_PIN_DIS] &
                       ~error_pin_low_in;

  // read mux; unmapped offsets and reserved bits read zero
  always_comb begin
    rd_data = 8'h00;
    unique case (reg_ptr)
      `MDCR_OFF_ADDR: rd_data = {1'h0, bus_address};
      `MDCR_OFF_BRIDGE: rd_data = bridge_control;
      `MDCR_OFF_PROT: rd_data = {clear_faults_cmd,
                                 protection_control[6:0]};
      `MDCR_OFF_STATUS: rd_data = {1'h0, edge_rate_select, 1'h0,
                                   ~error_pin_low_in,
                                   fault_flags};
      default: rd_data = 8'h00;
    endcase
  end

  // byte-level slave; start and stop override any phase
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state <= MDCR_IDLE;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      bit_cnt <= 4'h0;
      reg_ptr <= 8'h00;
      read_dir <= 1'h0;
      active_addr <= `MDCR_ADDR_RESET;
      sda_oe_n <= 1'h1;
      wr_strobe <= 1'h0;
      wr_data <= 8'h00;
    end else begin
      wr_strobe <= 1'h0;
      if (start_seen) begin
        // address written earlier takes effect here
        active_addr <= bus_address;
        state <= MDCR_ADDR;
        bit_cnt <= 4'h0;
        sda_oe_n <= 1'h1;
      end else if (stop_seen) begin
        state <= MDCR_IDLE;
        sda_oe_n <= 1'h1;
      end else begin
        if (scl_rise) begin
          shift_in <= {shift_in[6:0], sda_in};
          bit_cnt <= bit_cnt + 4'h1;
        end
        unique case (state)
          MDCR_IDLE: begin
            sda_oe_n <= 1'h1;
          end
          MDCR_ADDR: begin
            if (scl_fall && bit_cnt == 4'h8) begin
              // only a matching address is acknowledged
              if (shift_in[7:1] == active_addr && !bus_release) begin
                sda_oe_n <= 1'h0;
                read_dir <= shift_in[0];
                state <= MDCR_ADDR_ACK;
              end else begin
                state <= MDCR_IDLE;
              end
            end
          end
          MDCR_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (read_dir) begin
                // the pointer from the write phase selects the byte
                shift_out <= {rd_data[6:0], 1'h1};
                sda_oe_n <= rd_data[7];
                state <= MDCR_RDATA;
              end else begin
                sda_oe_n <= 1'h1;
                state <= MDCR_REG;
              end
            end
          end
          MDCR_REG: begin
            if (scl_fall && bit_cnt == 4'h8) begin
              reg_ptr <= shift_in;
              sda_oe_n <= 1'h0;
              state <= MDCR_REG_ACK;
            end
          end
          MDCR_REG_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              sda_oe_n <= 1'h1;
              state <= MDCR_WDATA;
            end
          end
          MDCR_WDATA: begin
            if (scl_fall && bit_cnt == 4'h8) begin
              wr_strobe <= 1'h1;
              wr_data <= shift_in;
              sda_oe_n <= 1'h0;
              state <= MDCR_WDATA_ACK;
            end
          end
          MDCR_WDATA_ACK: begin
            // one data byte per transfer, later bytes go unanswered
            if (scl_fall) begin
              sda_oe_n <= 1'h1;
              state <= MDCR_IDLE;
            end
          end
          MDCR_RDATA: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                sda_oe_n <= 1'h1;
                state <= MDCR_RDATA_ACK;
              end else begin
                sda_oe_n <= shift_out[7];
                shift_out <= {shift_out[6:0], 1'h1};
              end
            end
          end
          MDCR_RDATA_ACK: begin
            // master answers with nack, then stop
            if (scl_rise) begin
              state <= MDCR_IDLE;
            end
          end
        endcase
      end
    end
  end

  // address register, reserved top bit not stored
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      bus_address <= `MDCR_ADDR_RESET;
    end else if (wr_strobe && reg_ptr == `MDCR_OFF_ADDR) begin
      bus_address <= wr_data[6:0];
    end
  end

  // bridge_control, all bits writable
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      bridge_control <= `MDCR_BRIDGE_RESET;
    end else if (wr_strobe && reg_ptr == `MDCR_OFF_BRIDGE) begin
      bridge_control <= wr_data;
    end
  end

  // protection_control; reserved bit 5 forced to zero
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      protection_control <= `MDCR_PROT_RESET;
    end else if (wr_strobe && reg_ptr == `MDCR_OFF_PROT) begin
      protection_control <= {1'h0, wr_data[6], 1'h0,
                             wr_data[4:0]};
    end
  end

  // clear bit lives one cycle: the clear itself takes that cycle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      clear_faults_cmd <= 1'h0;
    end else begin
      clear_faults_cmd <= wr_strobe && reg_ptr == `MDCR_OFF_PROT &&
                          wr_data[`MDCR_PROT_CLEAR];
    end
  end

  // each write of a one to the trigger bit starts a check
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      open_load_check_start <= 1'h0;
    end else begin
      open_load_check_start <= wr_strobe &&
                               reg_ptr == `MDCR_OFF_PROT &&
                               wr_data[`MDCR_PROT_OLD_TRIG];
    end
  end

  // status register: only the edge rate bit is writable
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      edge_rate_select <= `MDCR_EDGE_RESET;
    end else if (wr_strobe && reg_ptr == `MDCR_OFF_STATUS) begin
      edge_rate_select <= wr_data[`MDCR_STATUS_EDGE];
    end
  end

  // settings to the power stage, registered
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      bridge_cfg <= mdcr_bridge_cfg_t'(9'(`MDCR_EDGE_RESET));
      overcurrent_response <= 1'h0;
      open_load_bridge_off <= 1'h0;
      edge_time_cycles <= EDGE_SLOW;
    end else begin
      bridge_cfg.torque_half_select <=
        bridge_control[`MDCR_BRIDGE_TORQUE];
      // source select: pins or the register copies of inputs four..one
      bridge_cfg.bridge_in <= bridge_control[`MDCR_BRIDGE_SRC] ?
                              bridge_control[6:3] :
                              bridge_pin_in;
      bridge_cfg.mode <= mdcr_mode_t'(bridge_control[1:0]);
      bridge_cfg.decay_slow <=
        protection_control[`MDCR_PROT_DECAY];
      bridge_cfg.edge_rate_select <= edge_rate_select;
      overcurrent_response <=
        protection_control[`MDCR_PROT_OCP_RESP];
      open_load_bridge_off <=
        protection_control[`MDCR_PROT_OLD_OFF];
      edge_time_cycles <= edge_rate_select ? EDGE_SLOW :
                          EDGE_FAST;
    end
  end

  property p_addr_reset;
    @(posedge core_clk) $past(!resetn) && resetn |->
      bus_address == 7'h60 && active_addr == 7'h60;
  endproperty
  a_addr_reset: assert property (p_addr_reset)
    else $error("bus address not at reset value");

  property p_clear_self;
    @(posedge core_clk) disable iff (!resetn)
      clear_faults_cmd && !wr_strobe |=> !clear_faults_cmd;
  endproperty
  a_clear_self: assert property (p_clear_self)
    else $error("clear bit did not return to zero");

  property p_src_select;
    @(posedge core_clk) disable iff (!resetn)
      bridge_control[`MDCR_BRIDGE_SRC] |=>
      bridge_cfg.bridge_in == $past(bridge_control[6:3]);
  endproperty
  a_src_select: assert property (p_src_select)
    else $error("bridge inputs not from register bits");

  property p_pin_disable;
    @(posedge core_clk) disable iff (!resetn)
      protection_control[`MDCR_PROT_PIN_DIS] |=> error_pin_low_oe_n;
  endproperty
  a_pin_disable: assert property (p_pin_disable)
    else $error("disabled fault pin driven");

  property p_rsvd_zero;
    @(posedge core_clk) disable iff (!resetn)
      !protection_control[`MDCR_PROT_RSVD] && !protection_control[7];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bit stored");

  property p_mismatch_noack;
    @(posedge core_clk) disable iff (!resetn)
      state == MDCR_ADDR && scl_fall && bit_cnt == 4'h8 &&
      !start_seen && !stop_seen && shift_in[7:1] != active_addr
      |=> sda_oe_n && state == MDCR_IDLE;
  endproperty
  a_mismatch_noack: assert property (p_mismatch_noack)
    else $error("foreign address acknowledged");

  property p_status_mirror;
    @(posedge core_clk) disable iff (!resetn)
      reg_ptr == `MDCR_OFF_STATUS |->
      rd_data[4] == !error_pin_low_in && rd_data[3:0] == fault_flags;
  endproperty
  a_status_mirror: assert property (p_status_mirror)
    else $error("status byte wrong");

  property p_edge_time;
    @(posedge core_clk) disable iff (!resetn)
      edge_rate_select ##1 edge_rate_select |-> edge_time_cycles == 4'h8;
  endproperty
  a_edge_time: assert property (p_edge_time)
    else $error("slow edge count wrong");

  property p_trigger_pulse;
    @(posedge core_clk) disable iff (!resetn)
      wr_strobe && reg_ptr == `MDCR_OFF_PROT && wr_data[2] |=>
      open_load_check_start ##1 !open_load_check_start;
  endproperty
  a_trigger_pulse: assert property (p_trigger_pulse)
    else $error("open load check not started once");
endmodule

// *** hw/mdcr_fault_core.sv ***
// latched fault flags, clear handling, retry timer and fault pin
`timescale 1ns/1ps
`include "mdcr_params.svh"
module mdcr_fault_core #(
  parameter int RETRY_CYCLES = `MDCR_RETRY_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire mdcr_pkg::mdcr_fault_evt_t fault_evt,
  input wire logic clear_pulse,
  input wire logic old_suppress,
  input wire logic pin_disable,
  input wire logic latch_mode,
  input wire logic old_bridge_off,
  output logic [3:0] flags,
  output logic pin_oe_n,
  output logic bridge_hiz
);
  import mdcr_pkg::*;

  logic overcurrent_flag; // sticky overcurrent
  logic open_load_flag; // sticky open load, reset only
  logic thermal_trip_flag; // sticky thermal shutdown
  logic undervoltage_flag; // sticky undervoltage
  logic [15:0] retry_cnt; // auto-retry countdown
  logic fault_active; // anything that pulls the pin

  // set wins over clear so no event is lost in the clear cycle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      overcurrent_flag <= 1'h0;
      open_load_flag <= 1'h0;
      thermal_trip_flag <= 1'h0;
      undervoltage_flag <= 1'h0;
    end else begin
      overcurrent_flag <= (overcurrent_flag & ~clear_pulse) |
                          fault_evt.overcurrent;
      thermal_trip_flag <= (thermal_trip_flag & ~clear_pulse) |
                           fault_evt.thermal;
      undervoltage_flag <= (undervoltage_flag & ~clear_pulse) |
                           fault_evt.undervoltage;
      // open load survives the clear command
      open_load_flag <= open_load_flag | fault_evt.open_load;
    end
  end

  // retry wait restarts on every overcurrent event
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      retry_cnt <= 16'h0000;
    end else if (fault_evt.overcurrent) begin
      retry_cnt <= 16'(RETRY_CYCLES);
    end else if (retry_cnt != 16'h0000) begin
      retry_cnt <= retry_cnt - 16'h0001;
    end
  end

  assign fault_active = overcurrent_flag | thermal_trip_flag |
                        undervoltage_flag |
                        (open_load_flag & ~old_suppress);

  // open-drain pin, enable low while pulling low
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pin_oe_n <= 1'h1;
    end else begin
      pin_oe_n <= ~(fault_active & ~pin_disable);
    end
  end

  // latch mode holds off until cleared, auto mode waits out the retry
  assign bridge_hiz = fault_evt.thermal | fault_evt.undervoltage |
                      (latch_mode ? overcurrent_flag :
                       (retry_cnt != 16'h0000)) |
                      (open_load_flag & old_bridge_off);

  assign flags = {overcurrent_flag, open_load_flag, thermal_trip_flag,
                  undervoltage_flag};

  property p_clear_keeps_old;
    @(posedge core_clk) disable iff (!resetn)
      open_load_flag && clear_pulse |=> open_load_flag;
  endproperty
  a_clear_keeps_old: assert property (p_clear_keeps_old)
    else $error("open load flag lost on clear");

  property p_clear_drops_ocp;
    @(posedge core_clk) disable iff (!resetn)
      clear_pulse && !fault_evt.overcurrent |=> !overcurrent_flag;
  endproperty
  a_clear_drops_ocp: assert property (p_clear_drops_ocp)
    else $error("overcurrent flag not cleared");

  property p_latch_hiz;
    @(posedge core_clk) disable iff (!resetn)
      latch_mode && overcurrent_flag |-> bridge_hiz;
  endproperty
  a_latch_hiz: assert property (p_latch_hiz)
    else $error("latched overcurrent left bridge on");
endmodule

// *** hw/mdcr_params.svh ***
// constants for the motor driver configuration register bank
`ifndef MDCR_PARAMS_SVH
`define MDCR_PARAMS_SVH

// register offsets, reached through the two-wire bus pointer
`define MDCR_OFF_ADDR 8'h00
`define MDCR_OFF_BRIDGE 8'h01
`define MDCR_OFF_PROT 8'h02
`define MDCR_OFF_STATUS 8'h03

// reset values
`define MDCR_ADDR_RESET 7'h60
`define MDCR_BRIDGE_RESET 8'h00
`define MDCR_PROT_RESET 8'h00
`define MDCR_STATUS_RESET 8'h40
`define MDCR_EDGE_RESET 1'h1

// protection_control field positions
`define MDCR_PROT_CLEAR 7
`define MDCR_PROT_PIN_DIS 6
`define MDCR_PROT_RSVD 5
`define MDCR_PROT_DECAY 4
`define MDCR_PROT_OCP_RESP 3
`define MDCR_PROT_OLD_TRIG 2
`define MDCR_PROT_OLD_SUPP 1
`define MDCR_PROT_OLD_OFF 0

// bridge_control and status field positions
`define MDCR_BRIDGE_TORQUE 7
`define MDCR_BRIDGE_SRC 2
`define MDCR_STATUS_EDGE 6

// timing: clock period and output edge times in ns
`define MDCR_CLK_NS 40
`define MDCR_EDGE_FAST_NS 150
`define MDCR_EDGE_SLOW_NS 300
`define MDCR_EDGE_FAST_CYC \
  ((`MDCR_EDGE_FAST_NS + `MDCR_CLK_NS - 1) / `MDCR_CLK_NS)
`define MDCR_EDGE_SLOW_CYC \
  ((`MDCR_EDGE_SLOW_NS + `MDCR_CLK_NS - 1) / `MDCR_CLK_NS)

// overcurrent auto-retry wait in cycles, value not fixed elsewhere
`define MDCR_RETRY_CYCLES 1024

`endif

// *** hw/mdcr_pkg.sv ***
// types shared by the motor driver configuration register bank
package mdcr_pkg;

  // bridge interface modes
  typedef enum logic [1:0] {
    MDCR_MODE_FOUR_PIN = 2'h0,
    MDCR_MODE_TWO_PIN = 2'h1,
    MDCR_MODE_PARALLEL = 2'h2,
    MDCR_MODE_HALF = 2'h3
  } mdcr_mode_t;

  // raw events from the detection circuits, one level each
  typedef struct packed {
    logic overcurrent;
    logic open_load;
    logic thermal;
    logic undervoltage;
  } mdcr_fault_evt_t;

  // settings handed to the power stage
  typedef struct packed {
    logic torque_half_select;
    logic [3:0] bridge_in;
    mdcr_mode_t mode;
    logic decay_slow;
    logic edge_rate_select;
  } mdcr_bridge_cfg_t;

  // serial slave states
  typedef enum logic [3:0] {
    MDCR_IDLE, MDCR_ADDR, MDCR_ADDR_ACK, MDCR_REG, MDCR_REG_ACK,
    MDCR_WDATA, MDCR_WDATA_ACK, MDCR_RDATA, MDCR_RDATA_ACK
  } mdcr_state_t;

endpackage
